// ===== verilog/lw_term_defs.vh
// Constants for the long-write termination controller
`ifndef LW_TERM_DEFS_VH
`define LW_TERM_DEFS_VH

// Register byte offsets
`define LWT_CTRL_OFF        4'h0
`define LWT_STAT_OFF        4'h4
`define LWT_CNT_OFF         4'h8

// Control register fields
`define LWT_CTRL_LWE_BIT    0

// Status register fields
`define LWT_STAT_BUSY_BIT   0
`define LWT_STAT_VPP_BIT    1
`define LWT_STAT_ACT_LO     2
`define LWT_STAT_ACT_HI     3
`define LWT_STAT_SRC_LO     8

// Reset values
`define LWT_LWE_RST         1'b0
`define LWT_CNT_RST         16'h0000

// Termination actions
`define LWT_ACT_NONE        2'h0
`define LWT_ACT_NEXT        2'h1
`define LWT_ACT_LOW         2'h2
`define LWT_ACT_HIGH        2'h3

// AXI responses
`define LWT_RESP_OKAY       2'h0
`define LWT_RESP_SLVERR     2'h2

`endif

// ===== verilog/long_write_termination_ctrl.v
// Long-write termination controller with AXI4-Lite register access
`timescale 1ns/10ps
`default_nettype none
`include "lw_term_defs.vh"
// One clock and one synchronous active-low reset, which stands for both
// the power-on and the master-clear reset.

module long_write_termination_ctrl #(
    parameter NUM_SRC = 8,                              // Interrupt sources watched
    parameter PTR_W   = 22                              // Table pointer width
) (
    input  wire               aclk,
    input  wire               aresetn,
    // Four-bit offsets: three word registers, the rest unmapped
    // AXI4-Lite slave
    input  wire [3:0]         s_axi_awaddr,
    input  wire               s_axi_awvalid,
    output wire               s_axi_awready,
    input  wire [31:0]        s_axi_wdata,
    input  wire [3:0]         s_axi_wstrb,
    input  wire               s_axi_wvalid,
    output wire               s_axi_wready,
    output reg  [1:0]         s_axi_bresp,
    output reg                s_axi_bvalid,
    input  wire               s_axi_bready,
    input  wire [3:0]         s_axi_araddr,
    input  wire               s_axi_arvalid,
    output wire               s_axi_arready,
    output reg  [31:0]        s_axi_rdata,
    output reg  [1:0]         s_axi_rresp,
    output reg                s_axi_rvalid,
    input  wire               s_axi_rready,
    // Core table-write path
    input  wire               table_write_instr,
    input  wire [PTR_W-1:0]   table_byte_pointer,
    input  wire [7:0]         table_byte_latch,
    input  wire               master_clear_prog_voltage_pin,
    // Levels from the interrupt controller; flags are never written here
    // Interrupt controller view
    input  wire [NUM_SRC-1:0] irq_flag,
    input  wire [NUM_SRC-1:0] irq_enable,
    input  wire [NUM_SRC-1:0] irq_priority,
    input  wire               global_or_high_irq_enable,
    input  wire               peripheral_or_low_irq_enable,
    // Toward program memory and core
    output reg                prog_strobe,
    output reg  [PTR_W-1:0]   prog_addr,
    output reg  [15:0]        prog_data,
    output wire               core_halt,
    output reg                resume_next,
    output reg                vector_low,
    output reg                vector_high
);

    // Three-state sequencer. The stop state keeps the strobe low for a
    // full cycle before the core is released, so the array settles
    // before fetch resumes.
    // Binary codes; code 3 is unused and falls back to idle.
    localparam [1:0] ST_IDLE = 2'h0;                    // Core runs
    localparam [1:0] ST_PROG = 2'h1;                    // Programming phase
    localparam [1:0] ST_STOP = 2'h2;                    // Strobe dropped, resume next

    // Sequencer and status registers. The count wraps silently at
    // 16 bits; software that needs more must read it often enough.
    // Bus-side holding registers follow.
    reg  [1:0]  state_q;                                // Sequencer state
    reg         lwe_q;                                  // Long-write enable
    reg  [7:0]  hold_q;                                 // Even-byte holding register
    reg  [1:0]  act_q;                                  // Pending / last action
    reg  [7:0]  src_q;                                  // Terminating source index
    reg  [15:0] cnt_q;                                  // Completed long writes
    reg  [3:0]  awaddr_q;                               // Latched write address
    reg         aw_full_q;                              // Write address held
    reg  [31:0] wdata_q;                                // Latched write data
    reg  [3:0]  wstrb_q;                                // Latched byte enables
    reg         w_full_q;                               // Write data held

    // Termination is level based: a flag already set when the write
    // starts ends it after one programming cycle. Software must clear
    // the source flag before the odd write, or the write is cut short.
    // Disabled sources are masked here and never reach the sequencer.
    wire [NUM_SRC-1:0] hits = irq_flag & irq_enable;    // Qualifying sources
    wire        term_hit = |hits;                       // Flag clear keeps waiting
    wire        odd_wr   = table_write_instr & table_byte_pointer[0];
    wire        start_lw = odd_wr & lwe_q & master_clear_prog_voltage_pin;
    // A write completes once both halves are held and no response
    // is still waiting for bready
    wire        do_write = aw_full_q & w_full_q & ~s_axi_bvalid;

    // Index of the lowest qualifying source
    // Scanning from the top down lets the lowest set bit win, so when
    // several enabled sources fire together the lowest index is reported
    // and its priority bit selects the vector.
    function [7:0] first_src;
        input [NUM_SRC-1:0] v;
        integer i;
        begin
            first_src = 8'h00;
            for (i = NUM_SRC - 1; i >= 0; i = i - 1) begin
                if (v[i]) begin
                    first_src = i[7:0];
                end
            end
        end
    endfunction

    // Action on termination from global enables and priority
    // With both enables set the source's own priority picks the vector;
    // with neither set the core simply resumes. The result is latched,
    // so enables that change during the stop cycle do not alter the
    // chosen action.
    function [1:0] pick_action;
        input gh;
        input gl;
        input pri;
        begin
            case ({gh, gl})
                2'b01:   pick_action = pri ? `LWT_ACT_NEXT : `LWT_ACT_LOW;
                2'b10:   pick_action = pri ? `LWT_ACT_HIGH : `LWT_ACT_NEXT;
                2'b11:   pick_action = pri ? `LWT_ACT_HIGH : `LWT_ACT_LOW;
                default: pick_action = `LWT_ACT_NEXT;
            endcase
        end
    endfunction

    wire [7:0] src_idx = first_src(hits);
    // Priority of the chosen source; the index is cut to the bits
    // that address NUM_SRC entries
    wire       src_pri = irq_priority[src_idx[$clog2(NUM_SRC > 1 ? NUM_SRC : 2)-1:0]];

    // Core stays stalled through the stop cycle
    // Halt comes straight from the state, so it rises with the strobe
    // and stays up one cycle longer than it
    assign core_halt = (state_q == ST_PROG) | (state_q == ST_STOP);

    // Sequencer: start, program, terminate
    // Writes arriving while the core is halted are ignored: the core
    // cannot issue them, and taking them would corrupt the held word.
    // Only one long write can be in flight, so no queue is needed.
    // No minimum programming time is enforced; software owns that.
    always @(posedge aclk) begin
        if (!aresetn) begin
            // Reset aborts any write in progress
            // No pulse for an aborted write; the core restarts and
            // should check the word it was programming
            state_q     <= ST_IDLE;
            prog_strobe <= 1'b0;
            prog_addr   <= {PTR_W{1'b0}};
            prog_data   <= 16'h0000;
            hold_q      <= 8'h00;
            act_q       <= `LWT_ACT_NONE;
            src_q       <= 8'h00;
            cnt_q       <= `LWT_CNT_RST;
            resume_next <= 1'b0;
            vector_low  <= 1'b0;
            vector_high <= 1'b0;
        end else begin
            resume_next <= 1'b0;
            vector_low  <= 1'b0;
            vector_high <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    // Even byte is a short write into the holding register
                    if (table_write_instr && !table_byte_pointer[0]) begin
                        hold_q <= table_byte_latch;
                    end
                    // Odd byte starts programming only when allowed
                    if (start_lw) begin
                        state_q     <= ST_PROG;
                        prog_strobe <= 1'b1;
                        prog_addr   <= {table_byte_pointer[PTR_W-1:1], 1'b0};
                        prog_data   <= {table_byte_latch, hold_q};
                    end
                end
                ST_PROG: begin
                    // Strobe stays high while no enabled flag is seen
                    // Only a qualifying flag ends it; flags untouched
                    if (term_hit) begin
                        state_q     <= ST_STOP;
                        prog_strobe <= 1'b0;
                        src_q       <= src_idx;
                        act_q       <= pick_action(global_or_high_irq_enable,
                                                   peripheral_or_low_irq_enable, src_pri);
                        cnt_q       <= cnt_q + 16'h0001;
                    end
                end
                ST_STOP: begin
                    // Strobe already low; now release core
                    // Exactly one pulse, for one cycle; act_q is kept
                    // so status reads show the last action afterwards
                    state_q     <= ST_IDLE;
                    resume_next <= (act_q == `LWT_ACT_NEXT);
                    vector_low  <= (act_q == `LWT_ACT_LOW);
                    vector_high <= (act_q == `LWT_ACT_HIGH);
                end
                default: begin
                    state_q     <= ST_IDLE;
                    prog_strobe <= 1'b0;
                end
            endcase
        end
    end

    // Enable bit: software may set, only reset clears
    // A write of zero is answered OKAY but changes nothing. Only a write
    // to the control offset with byte lane 0 enabled sets the bit, the
    // same address check that decides the write response.
    always @(posedge aclk) begin
        if (!aresetn) begin
            lwe_q <= `LWT_LWE_RST;
        end else if (do_write && awaddr_q == `LWT_CTRL_OFF && wstrb_q[0]
                     && wdata_q[`LWT_CTRL_LWE_BIT]) begin
            lwe_q <= 1'b1;
        end
    end

    // AXI address/data capture, either order
    // Address and data are taken independently and held until the
    // response handshake, so a master may offer them in either order.
    // Ready is simply slot empty; the cost is one idle cycle after
    // each response before the next write can be taken.
    assign s_axi_awready = ~aw_full_q;
    assign s_axi_wready  = ~w_full_q;
    assign s_axi_arready = ~s_axi_rvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            // Reset empties both slots and withdraws any response
            aw_full_q    <= 1'b0;
            w_full_q     <= 1'b0;
            awaddr_q     <= 4'h0;
            wdata_q      <= 32'h00000000;
            wstrb_q      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `LWT_RESP_OKAY;
        end else begin
            // Hold address until response taken
            if (s_axi_awvalid && !aw_full_q) begin
                aw_full_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_full_q) begin
                w_full_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            // Only the control offset accepts writes; all else is SLVERR
            // Response once both halves are in
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_q == `LWT_CTRL_OFF) ? `LWT_RESP_OKAY : `LWT_RESP_SLVERR;
            end
            // Response taken: free both slots for the next write
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_full_q    <= 1'b0;
                w_full_q     <= 1'b0;
            end
        end
    end

    // Read path: one cycle after address taken
    // One read in flight; arready drops while the answer stands.
    // Status is sampled at address acceptance, so halt and pin show
    // that cycle rather than the one in which rready is seen.
    always @(posedge aclk) begin
        if (!aresetn) begin
            // Reset withdraws any pending read answer
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `LWT_RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `LWT_RESP_OKAY;
            // Full four-bit decode, so unaligned offsets read as unmapped
            case (s_axi_araddr)
                `LWT_CTRL_OFF: s_axi_rdata <= {31'h00000000, lwe_q};
                `LWT_STAT_OFF: s_axi_rdata <= {16'h0000, src_q, 4'h0, act_q,
                                               master_clear_prog_voltage_pin, core_halt};
                `LWT_CNT_OFF:  s_axi_rdata <= {16'h0000, cnt_q};
                default: begin
                    // Unmapped: zero data, error
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `LWT_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            // Answer taken; arready returns next cycle
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // long_write_termination_ctrl
`default_nettype wire

// ===== testbench/irq_source_model.sv
// Interrupt-controller stand-in that raises a chosen flag after a delay
`timescale 1ns/10ps
`default_nettype none
module irq_source_model (
    input  wire logic       aclk,
    input  wire logic       arm,      // Start a countdown
    input  wire logic [2:0] src,      // Source whose flag will rise
    input  wire logic [7:0] dly,      // Cycles to wait, 0 answers promptly
    input  wire logic       clr,      // Software clears every flag
    output var  logic [7:0] irq_flag  // Flags, held until software clears
);
    logic [8:0] cnt_q;                // Countdown, 0 means idle
    // Flags accumulate; only the software clear drops them
    always @(posedge aclk) begin
        if (clr) begin
            irq_flag <= 8'h00;
            cnt_q    <= 9'h000;
        end else if (arm) begin
            cnt_q <= {1'b0, dly} + 9'h001;
        end else if (cnt_q == 9'h001) begin
            irq_flag[src] <= 1'b1;
            cnt_q         <= 9'h000;
        end else if (cnt_q != 9'h000) begin
            cnt_q <= cnt_q - 9'h001;
        end
    end
endmodule // irq_source_model
`default_nettype wire

// ===== testbench/long_write_termination_ctrl_assertions.sv
// Port-level checks for the long-write termination controller
`timescale 1ns/10ps
`default_nettype none
module lwt_checker #(
    parameter NUM_SRC = 8,
    parameter PTR_W   = 22
) (
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic               table_write_instr,
    input wire logic [PTR_W-1:0]   table_byte_pointer,
    input wire logic               master_clear_prog_voltage_pin,
    input wire logic [NUM_SRC-1:0] irq_flag,
    input wire logic [NUM_SRC-1:0] irq_enable,
    input wire logic               global_or_high_irq_enable,
    input wire logic               peripheral_or_low_irq_enable,
    input wire logic               prog_strobe,
    input wire logic               core_halt,
    input wire logic               resume_next,
    input wire logic               vector_low,
    input wire logic               vector_high
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire hit = |(irq_flag & irq_enable);               // Enabled source fired
    wire act = resume_next | vector_low | vector_high; // Any resume pulse
    wire go  = table_write_instr & ~core_halt;         // Write accepted
    // Strobe off first, halt lifted a cycle later
    sequence stop_s;
        !prog_strobe && core_halt;
    endsequence
    sequence resume_s;
        !core_halt && act;
    endsequence
    even_no_start_a: assert property (go && !table_byte_pointer[0] |=> !prog_strobe)
        else $error("even write began programming");
    pin_no_start_a: assert property (go && !master_clear_prog_voltage_pin |=> !prog_strobe)
        else $error("programming without voltage");
    strobe_hold_a: assert property (prog_strobe && !hit |=> prog_strobe)
        else $error("strobe dropped without cause");
    term_order_a: assert property (prog_strobe && hit |=> stop_s ##1 resume_s)
        else $error("termination sequence wrong");
    halt_cover_a: assert property (prog_strobe |-> core_halt)
        else $error("core ran during programming");
    one_action_a: assert property ($onehot0({resume_next, vector_low, vector_high}))
        else $error("several resume pulses");
    pulse_cause_a: assert property (act |-> $past(core_halt) && !$past(prog_strobe))
        else $error("resume pulse without termination");
    high_vec_a: assert property (vector_high |-> $past(global_or_high_irq_enable, 2))
        else $error("high vector while disabled");
    low_vec_a: assert property (vector_low |-> $past(peripheral_or_low_irq_enable, 2))
        else $error("low vector while disabled");
endmodule // lwt_checker
bind long_write_termination_ctrl lwt_checker #(.NUM_SRC(NUM_SRC), .PTR_W(PTR_W)) chk_i (.*);
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the long-write termination controller
`timescale 1ns/10ps
`default_nettype none
`include "lw_term_defs.vh"
module testbench;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, table_write_instr, arm, clr;
    logic master_clear_prog_voltage_pin, global_or_high_irq_enable, peripheral_or_low_irq_enable;
    logic prog_strobe, core_halt, resume_next, vector_low, vector_high;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [21:0] table_byte_pointer, prog_addr;
    logic [15:0] prog_data;
    logic [7:0]  table_byte_latch, irq_flag, irq_enable, irq_priority, dly;
    logic [2:0]  src;
    int          error_cnt, cmp_count, i, n;
    localparam logic [15:0] ACT_TAB = 16'hED65; // Action per {high en, low en, priority}
    long_write_termination_ctrl uut (.*);
    irq_source_model partner (.*);
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // One register access; handshakes sampled mid-cycle so no edge race
    task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic [2:0] tk;
        logic       done;
        int         k = 0;
        s_axi_awaddr  <= a;
        s_axi_araddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= wr;
        s_axi_wvalid  <= wr;
        s_axi_arvalid <= !wr;
        do begin
            @(negedge aclk);
            tk   = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_arvalid & s_axi_arready};
            done = wr ? s_axi_bvalid : s_axi_rvalid;
            rs   = wr ? s_axi_bresp : s_axi_rresp;
            d    = s_axi_rdata;
            @(posedge aclk);
            if (tk[2]) s_axi_awvalid <= 1'b0;
            if (tk[1]) s_axi_wvalid <= 1'b0;
            if (tk[0]) s_axi_arvalid <= 1'b0;
            k++;
        end while (done !== 1'b1 && k < 40);
        if (done !== 1'b1) begin
            error_cnt++;
            end_of_test();
        end
    endtask
    // Table write pulse, then one idle cycle
    task automatic tw(input logic [21:0] p, input logic [7:0] b);
        table_write_instr  <= 1'b1;
        table_byte_pointer <= p;
        table_byte_latch   <= b;
        @(posedge aclk);
        table_write_instr <= 1'b0;
        @(posedge aclk);
    endtask
    // Ask the partner to raise a flag later
    task automatic fire(input logic [2:0] s, input logic [7:0] t);
        src <= s;
        dly <= t;
        arm <= 1'b1;
        @(posedge aclk);
        arm <= 1'b0;
        repeat (t + 8'h04) @(posedge aclk);
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, table_write_instr, arm} = 6'h00;
        {global_or_high_irq_enable, peripheral_or_low_irq_enable, irq_enable, irq_priority} = 18'h00000;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, table_byte_pointer, table_byte_latch, src, dly} = 81'h0;
        {s_axi_bready, s_axi_rready, clr, master_clear_prog_voltage_pin, s_axi_wstrb} = 8'hFF;
        error_cnt = 0;
        cmp_count = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        clr     <= 1'b0;
        axi(0, `LWT_CTRL_OFF, 0, r);
        chk("ctrl_reset", d, 0);
        axi(0, 4'hC, 0, r);
        chk("unmapped_resp", r, `LWT_RESP_SLVERR);
        axi(1, `LWT_STAT_OFF, 1, r);
        chk("ro_write_resp", r, `LWT_RESP_SLVERR);
        tw(22'h000101, 8'h11);
        chk("no_enable", prog_strobe, 0);
        axi(1, `LWT_CTRL_OFF, 1, r);
        chk("ctrl_write_resp", r, `LWT_RESP_OKAY);
        axi(1, `LWT_CTRL_OFF, 0, r);
        axi(0, `LWT_CTRL_OFF, 0, r);
        chk("enable_sticky", d[0], 1);
        master_clear_prog_voltage_pin <= 1'b0;
        tw(22'h000101, 8'h11);
        chk("no_voltage", prog_strobe, 0);
        master_clear_prog_voltage_pin <= 1'b1;
        // Every enable and priority combination, one source each
        for (i = 0; i < 8; i++) begin
            clr                          <= 1'b1;
            global_or_high_irq_enable    <= i[2];
            peripheral_or_low_irq_enable <= i[1];
            irq_priority                 <= {8{i[0]}};
            irq_enable                   <= 8'h01 << i;
            @(posedge aclk);
            clr <= 1'b0;
            tw({13'h0, i[7:0], 1'b0}, 8'h5A ^ i[7:0]);
            tw({13'h0, i[7:0], 1'b1}, 8'hC3);
            fire(3'(i ^ 1), 8'h02);
            chk("disabled_ignored", prog_strobe, 1);
            chk("prog_data", prog_data, {8'hC3, 8'h5A ^ i[7:0]});
            chk("prog_addr", prog_addr, {13'h0, i[7:0], 1'b0});
            fire(3'(i), 8'(i * 7));
            for (n = 0; n < 300 && core_halt !== 1'b0; n++) @(posedge aclk);
            chk("halt_released", n < 300, 1);
            if (n == 300) end_of_test();
            chk("flag_kept", irq_flag[i], 1);
            axi(0, `LWT_STAT_OFF, 0, r);
            chk("status", d[15:0], {i[7:0], 4'h0, ACT_TAB[2*i+:2], 2'b10});
        end
        axi(0, `LWT_CNT_OFF, 0, r);
        chk("term_count", d, 8);
        clr <= 1'b1;
        tw(22'h000200, 8'h01);
        tw(22'h000201, 8'h02);
        aresetn <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("reset_abort", {prog_strobe, core_halt}, 0);
        axi(0, `LWT_CTRL_OFF, 0, r);
        chk("reset_clears", d, 0);
        // Cut-short word is programmed again by software
        axi(1, `LWT_CTRL_OFF, 1, r);
        tw(22'h000200, 8'h01);
        tw(22'h000201, 8'h02);
        chk("rewrite_data", prog_data, 16'h0201);
        chk("rewrite_strobe", prog_strobe, 1);
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
